// File: core/coc_bank_cmp.sv
// equality check of two redundant switch words
`timescale 1ns/1ps
module coc_bank_cmp #(
  parameter int unsigned W = 2
) (
  input  wire logic [W-1:0] word_a,
  input  wire logic [W-1:0] word_b,
  output logic              same
);
  assign same = (word_a == word_b);
endmodule : coc_bank_cmp

// File: core/coc_curtain_ctrl.sv
// receiver configuration checking and safety output control
//
// Overview of operation
// - an open remote test contact stops the emitter and turns every safety output off.
// - the beam code is one or two, one by default, and must equal the paired emitter's code.
// - changing the beam code in run mode is accepted with no lockout.
// - differing redundant switch banks cause lockout at power-up.
// - disagreeing restart-mode switches show an error code on the display.
// - changing configuration switches while powered causes lockout.
// - in automatic restart the outputs turn on once checks pass and beams clear, again after each clear.
// - in latched mode the outputs stay off after power-up or blockage until a valid reset.
// - the monitor selector picks single channel, or dual-or-none by default.
// - monitor wiring that disagrees with the selector flags an error and refuses blanking.
// - the auxiliary output exists only with single-channel monitoring.
// - the auxiliary output mirrors the safety output pair.
// - coarse detection needs both switches, tolerates two blocked beams, and is off by default.
// - the push button toggles the display between normal and inverted.
// - any lockout forces the outputs off until the fault clears and a valid reset occurs.
`timescale 1ns/1ps
module coc_curtain_ctrl #(
  parameter int unsigned RST_MIN_CYC = coc_pkg::RST_MIN_CYC,
  parameter int unsigned RST_MAX_CYC = coc_pkg::RST_MAX_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             irq,
  // optics and self-test
  input  wire logic        test_contact_closed,
  input  wire logic [7:0]  blocked_beams,
  input  wire logic        selftest_ok,
  input  wire logic        sync_ok,
  input  wire logic        selftest_fault,
  // configuration switches
  input  wire logic        beam_code_two,
  input  wire logic        latch_bank_a,
  input  wire logic        latch_bank_b,
  input  wire logic        coarse_detection_a,
  input  wire logic        coarse_detection_b,
  input  wire logic        monitor_single_channel,
  input  wire logic        external_device_monitor_wired_single,
  input  wire logic        blank_cfg_req,
  input  wire logic        invert_button,
  input  wire logic        reset_contact_closed,
  // outputs
  output logic             emitter_enable,
  output logic             emitter_beam_code_two,
  output logic             safety_output_pair_a,
  output logic             safety_output_pair_b,
  output logic             aux_output,
  output logic             aux_output_en,
  output logic             monitor_error,
  output logic             blank_cfg_accept,
  output logic             coarse_detection_on,
  output logic             display_inverted,
  output logic [7:0]       diag_code,
  output logic             lockout
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  coc_pkg::coc_state_e              state_reg;
  logic [coc_pkg::CFG_W-1:0]        cfg_now;
  logic [coc_pkg::CFG_W-1:0]        cfg_snap_reg;
  logic [coc_pkg::INT_W-1:0]        int_stat_reg;
  logic [coc_pkg::INT_W-1:0]        int_mask_reg;
  logic [coc_pkg::INT_W-1:0]        int_ev;
  logic [coc_pkg::INT_W-1:0]        w1c;
  logic                             soft_test_reg;
  logic                             banks_same;
  logic                             cfg_same;
  logic                             reset_valid;
  logic                             restart_same;
  logic                             beams_clear;
  logic                             beams_ok;
  logic                             latched;
  logic                             fault_now;
  logic                             outputs_on;
  logic                             outputs_on_reg;
  logic                             mon_err_reg;
  logic                             button_reg;
  logic                             code_reg;
  logic [7:0]                       lock_code_reg;

  // ----------------------------------------------------------------
  // switch checking
  // ----------------------------------------------------------------
  assign cfg_now = {monitor_single_channel, latch_bank_a, coarse_detection_a,
                    latch_bank_b, coarse_detection_b};

  coc_bank_cmp #(.W(2)) u_bank_cmp (
    .word_a (cfg_now[3:2]),
    .word_b (cfg_now[1:0]),
    .same   (banks_same)
  );

  // the beam code is left out of the snapshot so it may change live
  coc_bank_cmp #(.W(coc_pkg::CFG_W)) u_cfg_cmp (
    .word_a (cfg_now),
    .word_b (cfg_snap_reg),
    .same   (cfg_same)
  );

  coc_reset_qual #(
    .CW      (coc_pkg::RST_CNT_W),
    .MIN_CYC (RST_MIN_CYC),
    .MAX_CYC (RST_MAX_CYC)
  ) u_reset_qual (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .closed      (reset_contact_closed),
    .valid_pulse (reset_valid)
  );

  assign restart_same = (latch_bank_a == latch_bank_b);
  assign latched      = cfg_snap_reg[3];
  assign fault_now    = !cfg_same || !banks_same || selftest_fault;

  // ----------------------------------------------------------------
  // beam evaluation
  // ----------------------------------------------------------------
  // coarse detection only from the snapshot, so a half-flipped pair never loosens it
  assign coarse_detection_on = cfg_snap_reg[2] && cfg_snap_reg[0];
  assign beams_clear = (blocked_beams == 8'h00)
                       || (coarse_detection_on && (blocked_beams <= coc_pkg::COARSE_TOL));
  // an open test contact looks like interrupted beams
  assign beams_ok    = beams_clear && test_contact_closed && !soft_test_reg;

  // ----------------------------------------------------------------
  // emitter side
  // ----------------------------------------------------------------
  assign emitter_enable = test_contact_closed && !soft_test_reg;

  // code follows the switch in every state, never a lockout cause
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      code_reg <= coc_pkg::CODE_ONE;
    end else begin
      code_reg <= beam_code_two;
    end
  end
  assign emitter_beam_code_two = code_reg;

  // ----------------------------------------------------------------
  // configuration snapshot
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_snap_reg <= '0;
    end else if (state_reg == coc_pkg::ST_SAMPLE) begin
      cfg_snap_reg <= cfg_now;
    end
  end

  // ----------------------------------------------------------------
  // receiver state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= coc_pkg::ST_SAMPLE;
    end else begin
      case (state_reg)
        coc_pkg::ST_SAMPLE: begin
          if (!banks_same || selftest_fault) begin
            state_reg <= coc_pkg::ST_LOCK;
          end else if (selftest_ok && sync_ok) begin
            if (latch_bank_a) begin
              state_reg <= coc_pkg::ST_WAIT;
            end else if (beams_ok) begin
              state_reg <= coc_pkg::ST_RUN;
            end else begin
              state_reg <= coc_pkg::ST_STOP;
            end
          end
        end
        coc_pkg::ST_STOP: begin
          if (fault_now) begin
            state_reg <= coc_pkg::ST_LOCK;
          end else if (beams_ok) begin
            state_reg <= coc_pkg::ST_RUN;
          end
        end
        coc_pkg::ST_RUN: begin
          if (fault_now) begin
            state_reg <= coc_pkg::ST_LOCK;
          end else if (!beams_ok) begin
            state_reg <= latched ? coc_pkg::ST_WAIT : coc_pkg::ST_STOP;
          end
        end
        coc_pkg::ST_WAIT: begin
          if (fault_now) begin
            state_reg <= coc_pkg::ST_LOCK;
          end else if (reset_valid && beams_ok) begin
            state_reg <= coc_pkg::ST_RUN;
          end
        end
        coc_pkg::ST_LOCK: begin
          // leaves only once the cause is gone and the operator resets
          if (reset_valid && !fault_now) begin
            state_reg <= (latched && beams_ok) ? coc_pkg::ST_RUN : coc_pkg::ST_STOP;
          end
        end
        default: begin
          state_reg <= coc_pkg::ST_LOCK;
        end
      endcase
    end
  end

  assign lockout    = (state_reg == coc_pkg::ST_LOCK);
  assign outputs_on = (state_reg == coc_pkg::ST_RUN) && beams_ok;

  // ----------------------------------------------------------------
  // safety and auxiliary outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      outputs_on_reg <= 1'b0;
    end else begin
      outputs_on_reg <= outputs_on;
    end
  end

  assign safety_output_pair_a = outputs_on_reg;
  assign safety_output_pair_b = outputs_on_reg;
  assign aux_output_en        = cfg_snap_reg[4] && (state_reg != coc_pkg::ST_SAMPLE);
  assign aux_output           = aux_output_en && outputs_on_reg;

  // ----------------------------------------------------------------
  // monitor wiring check
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mon_err_reg <= 1'b0;
    end else begin
      mon_err_reg <= (external_device_monitor_wired_single != monitor_single_channel);
    end
  end

  assign monitor_error    = mon_err_reg;
  assign blank_cfg_accept = blank_cfg_req && !mon_err_reg;

  // ----------------------------------------------------------------
  // display
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      button_reg       <= 1'b0;
      display_inverted <= 1'b0;
    end else begin
      button_reg <= invert_button;
      if (invert_button && !button_reg) begin
        display_inverted <= !display_inverted;
      end
    end
  end

  // cause of the lockout is held so the display keeps it after the switch is fixed
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lock_code_reg <= coc_pkg::DIAG_NONE;
    end else if (state_reg != coc_pkg::ST_LOCK) begin
      if (selftest_fault) begin
        lock_code_reg <= coc_pkg::DIAG_SELFTEST;
      end else if (!banks_same) begin
        lock_code_reg <= coc_pkg::DIAG_BANK;
      end else begin
        lock_code_reg <= coc_pkg::DIAG_CFG_CHG;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      diag_code <= coc_pkg::DIAG_NONE;
    end else if (!restart_same) begin
      diag_code <= coc_pkg::DIAG_RESTART;
    end else if (lockout) begin
      diag_code <= lock_code_reg;
    end else if (mon_err_reg) begin
      diag_code <= coc_pkg::DIAG_MONITOR;
    end else begin
      diag_code <= coc_pkg::DIAG_NONE;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign int_ev[coc_pkg::INT_LOCKOUT]  = (state_reg != coc_pkg::ST_LOCK) && fault_now
                                         && (state_reg != coc_pkg::ST_SAMPLE);
  assign int_ev[coc_pkg::INT_OUT_OFF]  = outputs_on_reg && !outputs_on;
  assign int_ev[coc_pkg::INT_MON_ERR]  = !mon_err_reg
                                         && (external_device_monitor_wired_single
                                             != monitor_single_channel);
  assign int_ev[coc_pkg::INT_RESET_OK] = reset_valid;

  assign w1c = (reg_wr && (reg_addr == coc_pkg::REG_INT_STAT))
               ? reg_wdata[coc_pkg::INT_W-1:0] : '0;

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= (int_stat_reg & ~w1c) | int_ev;
    end
  end

  assign irq = |(int_stat_reg & int_mask_reg);

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_mask_reg  <= coc_pkg::INT_MASK_RST;
      soft_test_reg <= coc_pkg::CTRL_RST;
    end else if (reg_wr) begin
      if (reg_addr == coc_pkg::REG_INT_MASK) begin
        int_mask_reg <= reg_wdata[coc_pkg::INT_W-1:0];
      end else if (reg_addr == coc_pkg::REG_CTRL_OFS) begin
        soft_test_reg <= reg_wdata[0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == coc_pkg::REG_STATE_OFS) begin
      reg_rdata <= {8'h00, diag_code, 3'h0, cfg_snap_reg, mon_err_reg, code_reg,
                    display_inverted, outputs_on_reg, lockout, state_reg};
    end else if (reg_addr == coc_pkg::REG_INT_STAT) begin
      reg_rdata <= {28'h0000000, int_stat_reg};
    end else if (reg_addr == coc_pkg::REG_INT_MASK) begin
      reg_rdata <= {28'h0000000, int_mask_reg};
    end else if (reg_addr == coc_pkg::REG_CTRL_OFS) begin
      reg_rdata <= {31'h00000000, soft_test_reg};
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : coc_curtain_ctrl

// File: core/coc_pkg.sv
// shared constants and types of the curtain output and configuration control block
package coc_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned CLK_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned RST_MIN_MS    = 250;
  localparam int unsigned RST_MAX_MS    = 2000;
  // CLK_PER_MS is a whole count, so both limits convert exactly without rounding
  localparam int unsigned RST_MIN_CYC   = RST_MIN_MS * CLK_PER_MS;
  localparam int unsigned RST_MAX_CYC   = RST_MAX_MS * CLK_PER_MS;
  localparam int unsigned RST_CNT_W     = 27;

  // ----------------------------------------------------------------
  // register map, word offsets in bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATE_OFS  = 8'h00;
  localparam logic [7:0] REG_INT_STAT   = 8'h04;
  localparam logic [7:0] REG_INT_MASK   = 8'h08;
  localparam logic [7:0] REG_CTRL_OFS   = 8'h0c;

  // interrupt bit positions
  localparam int unsigned INT_W         = 4;
  localparam int unsigned INT_LOCKOUT   = 0;
  localparam int unsigned INT_OUT_OFF   = 1;
  localparam int unsigned INT_MON_ERR   = 2;
  localparam int unsigned INT_RESET_OK  = 3;

  // reset values
  localparam logic [INT_W-1:0] INT_MASK_RST = 4'h0;
  localparam logic             CTRL_RST     = 1'b0;

  // ----------------------------------------------------------------
  // beam rules and configuration
  // ----------------------------------------------------------------
  localparam logic [7:0] COARSE_TOL     = 8'h02;
  localparam int unsigned CFG_W         = 5;
  localparam logic       CODE_ONE       = 1'b0;

  // ----------------------------------------------------------------
  // diagnostic display codes
  // ----------------------------------------------------------------
  localparam logic [7:0] DIAG_NONE      = 8'h00;
  localparam logic [7:0] DIAG_RESTART   = 8'h21;
  localparam logic [7:0] DIAG_BANK      = 8'h22;
  localparam logic [7:0] DIAG_CFG_CHG   = 8'h23;
  localparam logic [7:0] DIAG_MONITOR   = 8'h31;
  localparam logic [7:0] DIAG_SELFTEST  = 8'h41;

  // ----------------------------------------------------------------
  // receiver state, gray along sample-stop-run-wait-lock
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'h0,
    ST_STOP   = 3'h1,
    ST_RUN    = 3'h3,
    ST_WAIT   = 3'h2,
    ST_LOCK   = 3'h6
  } coc_state_e;
endpackage : coc_pkg

// File: core/coc_reset_qual.sv
// monitored open-closed-open reset switch qualifier
`timescale 1ns/1ps
module coc_reset_qual #(
  parameter int unsigned CW      = 27,
  parameter int unsigned MIN_CYC = 10,
  parameter int unsigned MAX_CYC = 80
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic closed,
  output logic      valid_pulse
);
  localparam logic [CW-1:0] MIN_V = CW'(MIN_CYC);
  localparam logic [CW-1:0] MAX_V = CW'(MAX_CYC);

  logic [CW-1:0] cnt_reg;
  logic          closed_reg;
  logic          seen_open_reg;

  // counter saturates just past the limit so a held switch never wraps
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (!closed) begin
      cnt_reg <= '0;
    end else if (cnt_reg <= MAX_V) begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  // a switch closed at power-up must open first: tied-down buttons never reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      closed_reg    <= 1'b0;
      seen_open_reg <= 1'b0;
    end else begin
      closed_reg <= closed;
      if (!closed) begin
        seen_open_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      valid_pulse <= 1'b0;
    end else begin
      valid_pulse <= closed_reg && !closed && seen_open_reg
                     && (cnt_reg >= MIN_V) && (cnt_reg <= MAX_V);
    end
  end
endmodule : coc_reset_qual

// File: testbench/coc_curtain_ctrl_checker.sv
// concurrent checks on the ports of the curtain control block
`timescale 1ns/1ps
module coc_curtain_ctrl_checker (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       test_contact_closed,
  input wire logic [7:0] blocked_beams,
  input wire logic       beam_code_two,
  input wire logic       latch_bank_a,
  input wire logic       latch_bank_b,
  input wire logic       monitor_single_channel,
  input wire logic       blank_cfg_req,
  input wire logic       invert_button,
  input wire logic       emitter_enable,
  input wire logic       emitter_beam_code_two,
  input wire logic       safety_output_pair_a,
  input wire logic       safety_output_pair_b,
  input wire logic       aux_output,
  input wire logic       aux_output_en,
  input wire logic       monitor_error,
  input wire logic       blank_cfg_accept,
  input wire logic       coarse_detection_on,
  input wire logic       display_inverted,
  input wire logic [7:0] diag_code,
  input wire logic       lockout
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff rst;

  sequence s_btn_rise;
    $rose(invert_button);
  endsequence
  // one cycle of slack for a registered edge detector
  sequence s_toggled;
    ##1 display_inverted != $past(display_inverted, 2);
  endsequence

  a_test_off: assert property (!test_contact_closed |-> !emitter_enable ##1 !safety_output_pair_a)
    else $error("open test contact left outputs on");
  a_pair_same: assert property (safety_output_pair_a == safety_output_pair_b)
    else $error("safety output channels differ");
  a_code_follow: assert property (!$past(rst) |-> emitter_beam_code_two == $past(beam_code_two))
    else $error("emitter code does not follow switch");
  a_bank_lock: assert property (latch_bank_a != latch_bank_b |-> ##[1:2] lockout)
    else $error("bank mismatch without lockout");
  a_restart_diag: assert property (latch_bank_a != latch_bank_b |-> ##[1:2] diag_code == coc_pkg::DIAG_RESTART)
    else $error("restart mismatch code missing");
  a_blank_refuse: assert property (blank_cfg_accept == (blank_cfg_req && !monitor_error))
    else $error("blanking accepted wrongly");
  a_aux_single: assert property (!monitor_single_channel && $stable(monitor_single_channel) && !lockout |-> !aux_output_en)
    else $error("aux output enabled without single channel");
  a_aux_mirror: assert property (aux_output == (aux_output_en && safety_output_pair_a))
    else $error("aux output does not mirror outputs");
  a_beam_tol: assert property (safety_output_pair_a && !$past(rst) |-> $past(blocked_beams) == 8'h00 || ($past(coarse_detection_on) && $past(blocked_beams) <= 8'h02))
    else $error("outputs on with beams blocked");
  a_invert_toggle: assert property (s_btn_rise |=> s_toggled)
    else $error("display did not toggle");
  a_lock_off: assert property (lockout |=> !safety_output_pair_a)
    else $error("outputs on in lockout");
endmodule : coc_curtain_ctrl_checker

bind coc_curtain_ctrl coc_curtain_ctrl_checker u_chk (
  .clk_sys(clk_sys), .rst(rst), .test_contact_closed(test_contact_closed),
  .blocked_beams(blocked_beams), .beam_code_two(beam_code_two),
  .latch_bank_a(latch_bank_a), .latch_bank_b(latch_bank_b),
  .monitor_single_channel(monitor_single_channel), .blank_cfg_req(blank_cfg_req),
  .invert_button(invert_button), .emitter_enable(emitter_enable),
  .emitter_beam_code_two(emitter_beam_code_two), .safety_output_pair_a(safety_output_pair_a),
  .safety_output_pair_b(safety_output_pair_b), .aux_output(aux_output),
  .aux_output_en(aux_output_en), .monitor_error(monitor_error),
  .blank_cfg_accept(blank_cfg_accept), .coarse_detection_on(coarse_detection_on),
  .display_inverted(display_inverted), .diag_code(diag_code), .lockout(lockout)
);

// File: testbench/coc_partner.sv
// reset switch model for the curtain control bench
`timescale 1ns/1ps
module coc_partner (
  input  wire logic       clk_sys,
  input  wire logic       press,
  input  wire logic [7:0] hold_cyc,
  output logic            reset_contact_closed
);
  logic [7:0] cnt_reg = 8'h00;

  // closes for hold_cyc edges, then reopens: open-closed-open
  always_ff @(posedge clk_sys) begin
    if (press) begin
      cnt_reg <= hold_cyc;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  assign reset_contact_closed = (cnt_reg != 8'h00);
endmodule : coc_partner

// File: testbench/test_coc_curtain_ctrl.sv
// self-checking bench of the curtain output and configuration control block
`timescale 1ns/1ps
module test_coc_curtain_ctrl;
  localparam int unsigned MIN_C = 10;
  localparam int unsigned MAX_C = 40;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_s = 1'b0, rd_s = 1'b0, tst = 1'b1, code2 = 1'b0, press = 1'b0;
  logic        lat_a = 1'b0, lat_b = 1'b0, crs_a = 1'b0, crs_b = 1'b0, btn = 1'b0;
  logic        single = 1'b0, wired = 1'b0, blank = 1'b0;
  logic [7:0]  blk = 8'h00, hold = 8'h00, b, diag;
  logic [31:0] rdata, rv;
  logic        irq, em_en, em_c2, out_a, out_b, aux, aux_en, mon_err, bl_acc, crs_on, inv;
  logic        lock, rc;
  int          err_count = 0, checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  coc_curtain_ctrl #(.RST_MIN_CYC(MIN_C), .RST_MAX_CYC(MAX_C)) dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_rdata(rdata), .irq(irq), .test_contact_closed(tst),
    .blocked_beams(blk), .selftest_ok(1'b1), .sync_ok(1'b1), .selftest_fault(1'b0),
    .beam_code_two(code2), .latch_bank_a(lat_a), .latch_bank_b(lat_b),
    .coarse_detection_a(crs_a), .coarse_detection_b(crs_b), .monitor_single_channel(single),
    .external_device_monitor_wired_single(wired), .blank_cfg_req(blank),
    .invert_button(btn), .reset_contact_closed(rc), .emitter_enable(em_en),
    .emitter_beam_code_two(em_c2), .safety_output_pair_a(out_a), .safety_output_pair_b(out_b),
    .aux_output(aux), .aux_output_en(aux_en), .monitor_error(mon_err),
    .blank_cfg_accept(bl_acc), .coarse_detection_on(crs_on), .display_inverted(inv),
    .diag_code(diag), .lockout(lock)
  );
  coc_partner u_sw (.clk_sys(clk_sys), .press(press), .hold_cyc(hold), .reset_contact_closed(rc));

  function automatic logic exp_on(input logic [7:0] n, input logic c);
    return (n == 8'h00) || (c && n <= 8'h02);
  endfunction : exp_on

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk_sys);
    wr_s  <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys);
    rd_s <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask : rd
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit
  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_word
  task automatic push(input logic [7:0] n);
    @(posedge clk_sys);
    hold  <= n;
    press <= 1'b1;
    @(posedge clk_sys);
    press <= 1'b0;
    cyc(int'(n) + 8);
  endtask : push
  task automatic pwr;
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(6);
  endtask : pwr
  task automatic set_blk(input logic [7:0] n, input int w);
    @(posedge clk_sys);
    blk <= n;
    cyc(w);
  endtask : set_blk
  task automatic results;
    $display("Mismatches %0d of %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    results();
  end

  initial begin
    void'($urandom(38));
    pwr();
    rd(coc_pkg::REG_INT_MASK, rv);
    chk_word("int_mask", 32'h0, rv);
    rd(8'hf0, rv);
    chk_word("unmapped", 32'h0, rv);
    chk_bit("out_a", 1'b1, out_a);
    chk_bit("aux_en", 1'b0, aux_en);
    chk_bit("crs_on", 1'b0, crs_on);
    chk_bit("em_c2", 1'b0, em_c2);
    for (int i = 0; i < 24; i++) begin
      b = (i == 0) ? 8'h01 : 8'($urandom_range(3, 0));
      set_blk(b, 3);
      chk_bit("auto out", exp_on(b, 1'b0), out_a);
    end
    set_blk(8'h00, 3);
    @(posedge clk_sys);
    tst <= 1'b0;
    cyc(3);
    chk_bit("em_en", 1'b0, em_en);
    chk_bit("out_b", 1'b0, out_b);
    @(posedge clk_sys);
    tst <= 1'b1;
    wr(coc_pkg::REG_CTRL_OFS, 32'h1);
    cyc(1);
    chk_bit("soft em_en", 1'b0, em_en);
    wr(coc_pkg::REG_CTRL_OFS, 32'h0);
    cyc(3);
    @(posedge clk_sys);
    code2 <= 1'b1;
    cyc(3);
    chk_bit("em_c2", 1'b1, em_c2);
    chk_bit("code lock", 1'b0, lock);
    chk_bit("code out", 1'b1, out_a);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      btn <= 1'b1;
      cyc(2);
      @(posedge clk_sys);
      btn <= 1'b0;
      cyc(2);
      chk_bit("inv", i == 0, inv);
    end
    @(posedge clk_sys);
    crs_a <= 1'b1;
    crs_b <= 1'b1;
    cyc(3);
    chk_bit("cfg lock", 1'b1, lock);
    chk_bit("cfg crs", 1'b0, crs_on);
    chk_word("cfg diag", 32'(coc_pkg::DIAG_CFG_CHG), 32'(diag));
    chk_bit("irq masked", 1'b0, irq);
    wr(coc_pkg::REG_INT_MASK, 32'h1);
    cyc(1);
    chk_bit("irq", 1'b1, irq);
    wr(coc_pkg::REG_INT_STAT, 32'h1);
    cyc(1);
    chk_bit("irq clr", 1'b0, irq);
    rd(coc_pkg::REG_INT_MASK, rv);
    chk_word("int_mask", 32'h1, rv);
    @(posedge clk_sys);
    crs_a <= 1'b0;
    crs_b <= 1'b0;
    push(8'h04);
    chk_bit("short press", 1'b1, lock);
    push(8'd20);
    chk_bit("unlock out", 1'b1, out_a);
    @(posedge clk_sys);
    {lat_a, lat_b, crs_a, crs_b, single, wired} <= 6'h3f;
    pwr();
    chk_bit("latch up", 1'b0, out_a);
    chk_bit("crs both", 1'b1, crs_on);
    chk_bit("aux_en 1", 1'b1, aux_en);
    set_blk(8'h02, 1);
    push(8'd20);
    chk_bit("coarse out", 1'b1, out_a);
    chk_bit("aux", 1'b1, aux);
    set_blk(8'h03, 3);
    chk_bit("three blk", 1'b0, out_a);
    chk_bit("aux off", 1'b0, aux);
    set_blk(8'h00, 4);
    chk_bit("stay off", 1'b0, out_a);
    push(8'd20);
    chk_bit("relatch", 1'b1, out_a);
    @(posedge clk_sys);
    wired <= 1'b0;
    blank <= 1'b1;
    cyc(3);
    chk_bit("mon_err", 1'b1, mon_err);
    chk_bit("bl_acc", 1'b0, bl_acc);
    @(posedge clk_sys);
    {lat_a, lat_b, crs_a, crs_b, single, wired, blank} <= 7'h40;
    pwr();
    chk_bit("bank lock", 1'b1, lock);
    chk_word("bank diag", 32'(coc_pkg::DIAG_RESTART), 32'(diag));
    chk_bit("bank out", 1'b0, out_a);
    results();
  end
endmodule : test_coc_curtain_ctrl
